//--- bench/lfw_ctl_props.sv
/*
  Port checker for lfw_ctl, bound to every instance of it.
  Assumes the register port and decoder events change on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lfw_ctl_props (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and events
    input wire logic carrier_level,
    input wire logic carrier_clock,
    input wire logic receiver_osc_clock,
    input wire lfw_pkg::lfw_evt_t dec_evt,
    // Outputs
    input wire logic rx_chain_on,
    input wire logic decoder_enable,
    input wire logic rx_irq
);
    import lfw_pkg::*;
    logic [7:0] ctl_q, ctl_d;
    logic car_q, car_d;
    logic [3:0] ien;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadow of control and mode select as software wrote them
    always_comb begin
        ctl_d = (reg_wr && reg_addr == ADDR_CTL) ? reg_wdata : ctl_q;
        car_d = (reg_wr && reg_addr == ADDR_MODE) ? reg_wdata[MODE_SEL_BIT] : car_q;
    end
    always_ff @(posedge clk) begin
        ctl_q <= sys_rst ? CTL_RST : ctl_d;
        car_q <= sys_rst ? MODE_RST[MODE_SEL_BIT] : car_d;
    end
    // Carrier enable counts only in carrier mode or with the decoder off
    assign ien = ctl_q[7:4] & {2'b11, car_q | ~ctl_q[3], 1'b1};
    a_ctl_read_back: assert property (reg_rd && reg_addr == ADDR_CTL
        |=> reg_rdata == $past(ctl_q)) else $error("control readback wrong");
    a_ack_reads_zero: assert property (reg_rd && reg_addr == ADDR_STAT
        |=> !reg_rdata[ST_ACK_BIT]) else $error("acknowledge bit read as one");
    a_irq_is_or: assert property (reg_rd && reg_addr == ADDR_STAT && $stable(ien)
        && $past(ien, 2) == ien |=> $past(rx_irq) == |(reg_rdata[7:4] & $past(ien)))
        else $error("irq differs from enabled flags");
    a_byte_irq: assert property (dec_evt.byte_done && ien[3] && ctl_q[3] && !car_q
        && $stable(ien) |=> rx_irq) else $error("byte event gave no irq");
    a_err_irq: assert property (dec_evt.manch_err && ien[2] && ctl_q[3] && !car_q
        && $stable(ien) |=> rx_irq) else $error("error event gave no irq");
    a_id_irq: assert property (dec_evt.id_match && ien[0] && ctl_q[3] && !car_q
        && $stable(ien) |=> rx_irq) else $error("id event gave no irq");
    a_irq_held: assert property ($fell(rx_irq) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("irq dropped without a write");
    a_dec_en_ctl: assert property ((reg_wr && reg_addr == ADDR_CTL)
        ##1 !(reg_wr && reg_addr == ADDR_CTL) |=> decoder_enable == $past(reg_wdata[3], 2))
        else $error("decoder enable does not follow control");
    c_irq_clear: cover property (rx_irq ##1 !rx_irq);
    c_chain_up: cover property ($rose(rx_chain_on));
    c_chain_drop: cover property ($fell(rx_chain_on) && !car_q);
endmodule // lfw_ctl_props
bind lfw_ctl lfw_ctl_props u_lfw_ctl_props (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .carrier_level(carrier_level), .carrier_clock(carrier_clock),
    .receiver_osc_clock(receiver_osc_clock), .dec_evt(dec_evt), .rx_chain_on(rx_chain_on),
    .decoder_enable(decoder_enable), .rx_irq(rx_irq));
`default_nettype wire

//--- bench/lfw_lf_tx.sv
/*
  LF transmitter model: carrier bursts while on is high.
  Assumes HALF clk cycles per half carrier period, at least 4.
*/
`timescale 1ns/1ps
`default_nettype none
module lfw_lf_tx #(
    parameter int HALF = 5
) (
    // Clock and burst request
    input wire logic clk,
    input wire logic on,
    // Carrier toward the receiver
    output logic carrier_level,
    output logic carrier_clock,
    output int rises
);
    int ph = 0;
    initial begin
        carrier_level = 1'b0;
        carrier_clock = 1'b0;
        rises = 0;
    end
    // Clock stands low between bursts; level leads the first edge so no edge is lost
    always @(posedge clk) begin
        carrier_level <= on;
        ph <= (!on || ph == 2 * HALF - 1) ? 0 : ph + 1;
        carrier_clock <= on && ph >= HALF;
        rises <= !on ? 0 : rises + int'(ph == HALF);
    end
endmodule // lfw_lf_tx
`default_nettype wire

//--- bench/tb_top.sv
/*
  Testbench for lfw_ctl: register tasks, carrier bursts, events.
  Assumes the auto-zero timer starts with the release of reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lfw_pkg::*;
    localparam int HALF = 5;
    localparam int AZP = AZ_PERIOD_CYC;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, on = 1'b0, osc = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic rx_chain_on, decoder_enable, rx_irq, car_lvl, car_clk;
    lfw_evt_t dec_evt = '0;
    int errors = 0, checks = 0, cyc = 0, rises, l;
    int tmo[4] = '{100, SYNC_TO_1_MS * 2, SYNC_TO_2_MS * 2, SYNC_TO_3_MS * 2};
    // Status bit and decoder event of the byte, error and ID flags, in that order
    logic [7:0] fb[3] = '{8'h80, 8'h40, 8'h10};
    logic [4:0] ev[3] = '{5'h10, 5'h08, 5'h04};
    lfw_ctl #(.AZ_PERIOD_CYCLES(AZP), .OSC_TICKS_PER_MS(2)) u_lfw_ctl (.clk(clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .carrier_level(car_lvl),
        .carrier_clock(car_clk), .receiver_osc_clock(osc), .dec_evt(dec_evt),
        .rx_chain_on(rx_chain_on), .decoder_enable(decoder_enable), .rx_irq(rx_irq));
    lfw_lf_tx #(.HALF(HALF)) u_lfw_lf_tx (.clk(clk), .on(on), .carrier_level(car_lvl),
        .carrier_clock(car_clk), .rises(rises));
    initial forever #12.5 clk = ~clk;
    // Cycle count since release, to keep bursts clear of auto-zero
    always @(posedge clk) cyc <= sys_rst ? 0 : cyc + 1;
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rdc(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) chk(reg_rdata & m, e);
    endtask
    task settle;
        repeat (3) @(negedge clk);
    endtask
    task pulse(input logic [4:0] e);
        @(posedge clk) dec_evt <= lfw_evt_t'(e);
        @(posedge clk) dec_evt <= '0;
    endtask
    task align(input int need);
        while (cyc % AZP < AZ_LEN_CYC + 140 || cyc % AZP > AZP - need) @(posedge clk);
    endtask
    task go(input logic w);
        int n;
        n = 0;
        @(posedge clk) on <= 1'b1;
        while ((w ? rx_irq : rx_chain_on) !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        // A burst that never validates counts as a mismatch
        if (n >= 20000) errors++;
    endtask
    // Carrier off and frame end leave the receiver idle for the next burst
    task stop;
        @(posedge clk) on <= 1'b0;
        pulse(5'h01);
        repeat (20) @(posedge clk);
    endtask
    task tick(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk) osc <= 1'b1;
            repeat (4) @(posedge clk) osc <= 1'b0;
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(ADDR_CTL, 8'hff, CTL_RST);
        rdc(ADDR_MODE, 8'hff, MODE_RST);
        rdc(ADDR_STAT, 8'hf1, 8'h00);
        chk(decoder_enable, 1'b1);
        wr(2'h3, 8'hff);
        rdc(2'h3, 8'hff, 8'h00);
        wr(ADDR_CTL, 8'hf3);
        rdc(ADDR_CTL, 8'hff, 8'hf3);
        settle;
        chk(decoder_enable, 1'b0);
        $display("test 1 done");
        wr(ADDR_CTL, 8'h2c);
        for (int c = 0; c < 16; c++) begin
            l = c > 7 ? 8 << (c - 8) : 8;
            wr(ADDR_MODE, 8'(c));
            align(l * 2 * HALF + 300);
            go(1'b0);
            chk(rises, l);
            chk(rx_irq, 1'b0);
            stop;
        end
        $display("test 2 done");
        wr(ADDR_MODE, 8'h09);
        while (cyc % AZP != AZP - 60) @(posedge clk);
        go(1'b0);
        l = AZ_LEN_CYC / (2 * HALF);
        chk({rises > l, rises < l + 16}, 2'b11);
        stop;
        $display("test 3 done");
        wr(ADDR_STAT, 8'h01);
        wr(ADDR_MODE, 8'h81);
        align(600);
        go(1'b1);
        chk(rises, 16);
        rdc(ADDR_STAT, 8'h21, 8'h20);
        stop;
        wr(ADDR_STAT, 8'h01);
        settle;
        chk(rx_irq, 1'b0);
        rdc(ADDR_STAT, 8'hf0, 8'h00);
        $display("test 4 done");
        wr(ADDR_CTL, 8'h0c);
        wr(ADDR_MODE, 8'h00);
        for (int i = 0; i < 3; i++) begin
            pulse(ev[i]);
            rdc(ADDR_STAT, 8'hf0, fb[i]);
            chk(rx_irq, 1'b0);
            wr(ADDR_CTL, 8'h0c | fb[i]);
            settle;
            chk(rx_irq, 1'b1);
            wr(ADDR_STAT, fb[i]);
            settle;
            chk(rx_irq, 1'b0);
            pulse(ev[i]);
            settle;
            chk(rx_irq, 1'b1);
            wr(ADDR_CTL, 8'h0c);
            wr(ADDR_STAT, 8'h01);
        end
        wr(ADDR_CTL, 8'hd0);
        pulse(5'h1c);
        rdc(ADDR_STAT, 8'hd0, 8'h00);
        chk(rx_irq, 1'b0);
        $display("test 5 done");
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_CTL, 8'h0c | 8'(t));
            wr(ADDR_MODE, 8'h08);
            align(400);
            go(1'b0);
            tick(t > 0 ? tmo[t] - 1 : tmo[0]);
            chk(rx_chain_on, 1'b1);
            if (t > 0) begin
                tick(1);
                repeat (10) @(posedge clk);
                chk(rx_chain_on, 1'b0);
            end
            stop;
        end
        // A SYNC found in time keeps the chain powered past the limit
        wr(ADDR_CTL, 8'h0d);
        align(400);
        go(1'b0);
        pulse(5'h02);
        tick(tmo[1] + 2);
        chk(rx_chain_on, 1'b1);
        stop;
        $display("test 6 done");
        wr(ADDR_CTL, 8'h00);
        go(1'b0);
        chk(rises < 2, 1'b1);
        // Decoder off: software polls the detector bit, carrier flag expected set
        rdc(ADDR_STAT, 8'h2e, 8'h2e);
        chk(rx_irq, 1'b0);
        stop;
        $display("test 7 done");
        end_of_test;
    end
    // Watchdog well above the roughly 46k cycles the tests take
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire

//--- verilog/lfw_ctl.sv
/*
  Control logic for a low-frequency wake-up receiver: carrier
  validation with auto-zero interleave, SYNC search timeout,
  receiver flags with local interrupt enables, register port.
  Assumes the carrier slicer, carrier clock and receiver oscillator
  arrive asynchronously on pins and decoder events arrive on clk.
*/
// Overview of operation
// R1 - Code 1000 validates a carrier after 8 periods in both modes.
// R2 - Codes 1001 to 1011 need 16, 32, 64 periods in both modes.
// R3 - Codes 1100 to 1111 need 128 to 1024 periods in both modes.
// R4 - A 64 us auto-zero runs every 1 ms, also inside long windows.
// R5 - Carrier present after auto-zero counts as present throughout it.
// R6 - A set flag with its enable set requests an unmaskable interrupt.
// R7 - Software should clear pending flags before enabling interrupts.
// R8 - Control bit 7 enables the received-byte interrupt; reset clears.
// R9 - Bit 6 enables the Manchester error interrupt; reset clears.
// R10 - Bit 5 enables carrier interrupt; ignored in data mode with decoder.
// R11 - Bit 4 enables the ID-match interrupt; reset clears.
// R12 - Bit 3 enables the decoder, reset sets; clear stops decoder flags.
// R13 - With decoder off software polls the detector output bit.
// R14 - Bit 2 enables carrier validation; reset sets it.
// R15 - Timeout field bounds SYNC search none/8/24/48 ms; receiver powers off.
// R16 - Timeout counted on receiver oscillator ticks; reset clears field.
// R17 - Mode bit 1 carrier mode, 0 data mode; validation gates power-up.
// R18 - Acknowledge bit clears all flags, self-clears, reads zero.
// R19 - Interrupt is OR of flag AND enable, held until flags clear.
`timescale 1ns/1ps
`default_nettype none
module lfw_ctl #(
    parameter int AZ_PERIOD_CYCLES = lfw_pkg::AZ_PERIOD_CYC,
    parameter int OSC_TICKS_PER_MS = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Analog front end pins
    input wire logic carrier_level,
    input wire logic carrier_clock,
    input wire logic receiver_osc_clock,
    // Decoder events
    input wire lfw_pkg::lfw_evt_t dec_evt,
    // Receiver control and interrupt
    output logic rx_chain_on,
    output logic decoder_enable,
    output logic rx_irq
);
    import lfw_pkg::*;

    localparam int SYNC_W = 16;

    // Validation length for a detect code in the selected mode
    function automatic logic [10:0] val_len(input logic [3:0] code, input logic car_mode);
        if (code[3] || car_mode) begin
            val_len = VAL_BASE << code[2:0]; // see R1, see R2, see R3
        end else begin
            val_len = VAL_BASE;
        end
    endfunction

    // SYNC search limit in oscillator ticks
    function automatic logic [SYNC_W-1:0] sync_limit(input logic [1:0] sel);
        case (sel)
            2'h1: sync_limit = SYNC_W'(SYNC_TO_1_MS * OSC_TICKS_PER_MS);
            2'h2: sync_limit = SYNC_W'(SYNC_TO_2_MS * OSC_TICKS_PER_MS);
            default: sync_limit = SYNC_W'(SYNC_TO_3_MS * OSC_TICKS_PER_MS);
        endcase
    endfunction

    // Three-stage pin synchronisers; a change counts once stages 2 and 3 agree
    logic [2:0] pin_raw;
    logic [2:0] s1_q, s2_q, s3_q, filt_q, filt_d, filt_old_q;
    assign pin_raw = {receiver_osc_clock, carrier_clock, carrier_level};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_comb begin
                filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                    s3_q[g] <= 1'b0;
                    filt_q[g] <= 1'b0;
                    filt_old_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    filt_q[g] <= filt_d[g];
                    filt_old_q[g] <= filt_q[g];
                end
            end
        end
    endgenerate

    logic car_on, car_tick, osc_tick;
    assign car_on = filt_q[0];
    assign car_tick = filt_q[1] & ~filt_old_q[1];
    assign osc_tick = filt_q[2] & ~filt_old_q[2];

    // Register state
    lfw_ctl_t ctl_q, ctl_d;
    logic [7:0] mode_q, mode_d;
    logic [3:0] flags_q, flags_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    // Validation and receiver state
    logic [31:0] az_cnt_q, az_cnt_d;
    logic [10:0] vcnt_q, vcnt_d;
    logic valid_q, valid_d;
    logic rx_on_q, rx_on_d;
    logic sync_seen_q, sync_seen_d;
    logic [SYNC_W-1:0] sync_cnt_q, sync_cnt_d;

    logic car_mode, dec_on, validate_hit;
    logic [3:0] flag_set, flag_clr, irq_en;
    assign car_mode = mode_q[MODE_SEL_BIT]; // see R17
    assign dec_on = ctl_q.digital_decoder_en;

    // Auto-zero timer, validation counter, receive chain power and SYNC search
    always_comb begin
        az_cnt_d = az_cnt_q + 32'd1;
        if (az_cnt_q >= 32'(AZ_PERIOD_CYCLES - 1)) begin
            az_cnt_d = '0; // see R4
        end
        vcnt_d = vcnt_q;
        valid_d = valid_q;
        rx_on_d = rx_on_q;
        sync_seen_d = sync_seen_q;
        sync_cnt_d = sync_cnt_q;
        validate_hit = 1'b0;
        if (!ctl_q.carrier_validation_en) begin
            // Validation off: a present carrier is accepted at once
            vcnt_d = '0;
            validate_hit = car_on && !valid_q; // see R14
        end else if (valid_q && !car_mode) begin
            vcnt_d = '0; // Detect time ignored once validated, see R17
        end else if (az_cnt_q < 32'(AZ_LEN_CYC)) begin
            // Counting frozen while the front end is auto-zeroed
            if (az_cnt_q == 32'(AZ_LEN_CYC - 1) && vcnt_q != '0) begin
                if (car_on) begin
                    vcnt_d = (vcnt_q > VAL_MAX - AZ_CREDIT) ? VAL_MAX : vcnt_q + AZ_CREDIT; // see R5
                end else begin
                    vcnt_d = '0;
                end
            end
        end else if (!car_on) begin
            vcnt_d = '0;
        end else if (car_tick && vcnt_q != VAL_MAX) begin
            vcnt_d = vcnt_q + 11'd1;
        end
        if (ctl_q.carrier_validation_en && !valid_q && vcnt_d >= val_len(mode_q[3:0], car_mode)) begin
            validate_hit = 1'b1; // see R1, see R2, see R3
        end
        if (validate_hit) begin
            vcnt_d = '0;
            valid_d = !car_mode;
            if (!car_mode) begin
                rx_on_d = 1'b1; // see R17
                sync_seen_d = 1'b0;
                sync_cnt_d = '0;
            end
        end
        if (car_mode) begin
            valid_d = 1'b0;
            rx_on_d = 1'b0;
        end else if (rx_on_q) begin
            if (dec_evt.sync_found && dec_on) begin
                sync_seen_d = 1'b1;
            end
            if (osc_tick && !sync_seen_q && ctl_q.sync_search_limit != SYNC_TO_NONE) begin
                sync_cnt_d = sync_cnt_q + SYNC_W'(1); // see R16
                if (sync_cnt_d >= sync_limit(ctl_q.sync_search_limit)) begin
                    rx_on_d = 1'b0; // see R15
                    valid_d = 1'b0;
                end
            end
            if (dec_evt.frame_end) begin
                rx_on_d = 1'b0;
                valid_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            az_cnt_q <= '0;
            vcnt_q <= '0;
            valid_q <= 1'b0;
            rx_on_q <= 1'b0;
            sync_seen_q <= 1'b0;
            sync_cnt_q <= '0;
        end else begin
            az_cnt_q <= az_cnt_d;
            vcnt_q <= vcnt_d;
            valid_q <= valid_d;
            rx_on_q <= rx_on_d;
            sync_seen_q <= sync_seen_d;
            sync_cnt_q <= sync_cnt_d;
        end
    end

    // Flag sources; decoder flags only in data mode with the decoder running
    always_comb begin
        flag_set = FLAGS_NONE;
        flag_set[3] = dec_evt.byte_done && dec_on && !car_mode; // see R12
        flag_set[2] = dec_evt.manch_err && dec_on && !car_mode; // see R12
        flag_set[FL_CAR] = validate_hit && (car_mode || !dec_on);
        flag_set[0] = dec_evt.id_match && dec_on && !car_mode; // see R12
    end

    // Local enables; carrier enable ignored in data mode with decoder on
    always_comb begin
        irq_en = {ctl_q.rx_byte_irq_en, ctl_q.rx_error_irq_en,
                  ctl_q.carrier_irq_en && (car_mode || !dec_on), ctl_q.id_match_irq_en}; // see R10
    end

    // Register writes, flag clears, interrupt and read data
    always_comb begin
        ctl_d = ctl_q;
        mode_d = mode_q;
        flag_clr = FLAGS_NONE;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CTL: ctl_d = lfw_ctl_t'(reg_wdata); // see R8, see R9, see R11
                ADDR_MODE: mode_d = reg_wdata;
                ADDR_STAT: begin
                    // One to a flag clears it; acknowledge clears all
                    flag_clr = reg_wdata[7:FLAG_LSB];
                    if (reg_wdata[ST_ACK_BIT]) begin
                        flag_clr = ~FLAGS_NONE; // see R18
                    end
                end
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        flags_d = (flags_q & ~flag_clr) | flag_set;
        // Not gated by any processor-wide mask, held while flags stay set
        irq_d = |(flags_d & irq_en); // see R6, see R19
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CTL: rdata_d = ctl_q;
                ADDR_MODE: rdata_d = mode_q;
                ADDR_STAT: begin
                    rdata_d[7:FLAG_LSB] = flags_q;
                    rdata_d[ST_RXON_BIT] = rx_on_q;
                    rdata_d[ST_VALID_BIT] = valid_q;
                    rdata_d[ST_DET_BIT] = car_on; // Polled stream, see R13
                    rdata_d[ST_ACK_BIT] = 1'b0; // see R18
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_q <= lfw_ctl_t'(CTL_RST); // see R12, see R14, see R16
            mode_q <= MODE_RST;
            flags_q <= FLAGS_NONE;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            mode_q <= mode_d;
            flags_q <= flags_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = rdata_q;
    assign rx_irq = irq_q;
    assign rx_chain_on = rx_on_q;
    assign decoder_enable = ctl_q.digital_decoder_en;
endmodule // lfw_ctl
`default_nettype wire

//--- verilog/lfw_pkg.sv
/*
  Package for the low-frequency wake-up receiver control block:
  register offsets, field positions, reset values, timing constants
  and the control register and decoder event types shared by the design.
  Assumes a 40 MHz system clock and a 125 kHz carrier.
*/
`default_nettype none
package lfw_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] ADDR_CTL = 2'h0; // lf_rx_irq_and_decode_ctl
    localparam logic [1:0] ADDR_MODE = 2'h1; // lf_rx_mode_timing_ctl
    localparam logic [1:0] ADDR_STAT = 2'h2; // lf_rx_status_reg
    // Control register reset: decoder and validation enabled
    localparam logic [7:0] CTL_RST = 8'h0c;
    // Mode register: carrier mode selected, detect code 0000
    localparam logic [7:0] MODE_RST = 8'h80;
    localparam int MODE_SEL_BIT = 7;
    // Status register field positions
    localparam int ST_RXON_BIT = 3;
    localparam int ST_VALID_BIT = 2;
    localparam int ST_DET_BIT = 1;
    localparam int ST_ACK_BIT = 0;
    // Flag nibble sits in bits 7:4 of both status and control
    localparam int FLAG_LSB = 4;
    localparam logic [3:0] FLAGS_NONE = 4'h0;
    localparam int FL_CAR = 1; // index inside the nibble
    // Validation lengths in carrier periods
    localparam logic [10:0] VAL_BASE = 11'h008;
    localparam logic [10:0] VAL_MAX = 11'h7ff;
    // Auto-zero: 64 us every 1 ms
    localparam int CLK_MHZ = 40;
    localparam int AZ_PERIOD_US = 1000;
    localparam int AZ_LEN_US = 64;
    localparam int AZ_PERIOD_CYC = AZ_PERIOD_US * CLK_MHZ;
    localparam int AZ_LEN_CYC = AZ_LEN_US * CLK_MHZ;
    // Carrier periods credited for one auto-zero (64 us at 8 us)
    localparam logic [10:0] AZ_CREDIT = 11'h008;
    // SYNC search limits in milliseconds
    localparam int SYNC_TO_1_MS = 8;
    localparam int SYNC_TO_2_MS = 24;
    localparam int SYNC_TO_3_MS = 48;
    localparam logic [1:0] SYNC_TO_NONE = 2'h0;

    // Control register layout
    typedef struct packed {
        logic rx_byte_irq_en;
        logic rx_error_irq_en;
        logic carrier_irq_en;
        logic id_match_irq_en;
        logic digital_decoder_en;
        logic carrier_validation_en;
        logic [1:0] sync_search_limit;
    } lfw_ctl_t;

    // Decoder events, one-cycle pulses on clk
    typedef struct packed {
        logic byte_done;
        logic manch_err;
        logic id_match;
        logic sync_found;
        logic frame_end;
    } lfw_evt_t;
endpackage
`default_nettype wire
